// ---- hdl/hpsc_pkg.sv ----
// Package of constants and types for the host port strap configuration block.
package hpsc_pkg;
    localparam int          STRAP_W       = 8;
    localparam int          MODE_LSB      = 0;
    localparam int          MODE_W        = 3;
    localparam logic [2:0]  MODE_GENERIC1 = 3'h3;
    localparam int          GPIO_IN_BIT   = 3;
    localparam int          ENDIAN_BIT    = 4;
    localparam int          WAITPOL_BIT   = 5;
    localparam int          DIV_LSB       = 6;
    localparam int          DIV_W         = 2;
    localparam int          ADDR_W        = 17;
    localparam int          DATA_W        = 16;
    localparam logic [16:0] REV_ID_OFFSET = 17'h00000;
    localparam int          BUF_BYTES     = 81920;
    localparam int          BUF_WORDS     = BUF_BYTES / 2;
    localparam int          BUF_AW        = 16;
    localparam int          REG_LAT       = 1;
    localparam logic [7:0]  REV_ID_VALUE  = 8'h5A; // Arbitrary revision value.
    typedef enum logic [1:0] {
        HPSC_IDLE = 2'b00,
        HPSC_WAIT = 2'b01,
        HPSC_DONE = 2'b10
    } hpsc_state_t;
endpackage

// ---- hdl/hpsc_mem.sv ----
// Display buffer memory with registered read data.
`timescale 1ns/1ns
module hpsc_mem #(
    parameter int WORDS = 40960,
    parameter int AW    = 16,
    parameter int DW    = 16
) (
    // Clock
    input  wire logic          clk,
    // Access
    input  wire logic          en,
    input  wire logic          we,
    input  wire logic [1:0]    be,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);
    if (DW != 16 || WORDS > (1 << AW)) begin : gShapeCheck
        $error("Memory shape is not supported.");
    end
    logic [DW-1:0] mem [WORDS];
    always_ff @(posedge clk) begin
        if (en && we && addr < AW'(WORDS)) begin
            if (be[0]) begin
                mem[addr][7:0] <= wdata[7:0];
            end
            if (be[1]) begin
                mem[addr][15:8] <= wdata[15:8];
            end
        end
        if (en && !we) begin
            rdata <= (addr < AW'(WORDS)) ? mem[addr] : '0;
        end
    end
endmodule

// ---- hdl/hpsc_top.sv ----
// Strap capture and host bus port of the display controller.
`timescale 1ns/1ns
// What this block does
// - Capture all eight straps at the first clock edge after reset is released.
// - Strap low bits 011 select the first generic host bus mode.
// - Strap bit three high makes GPIO inputs; low drives panel timing.
// - Strap bit four selects big-endian (1) or little-endian (0) host.
// - Strap bit five sets wait polarity; high means active-high wait.
// - Top two strap bits set input-to-bus clock divide 1:1 to 4:1.
// - Select input low reaches registers, high reaches the 80K display buffer.
// - Register offset zero reads the revision identification byte.
// - Wait stays asserted until read data ready or write accepted.
module hpsc_top
    import hpsc_pkg::*;
#(
    parameter logic [7:0] REV_ID = REV_ID_VALUE  // Arbitrary revision value.
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // Straps
    input  wire logic [STRAP_W-1:0] configStrap,
    // Host bus
    input  wire logic              csN,
    input  wire logic              memRegSel,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              rdN,
    input  wire logic [1:0]        weN,
    input  wire logic [DATA_W-1:0] dataIn,
    output logic      [DATA_W-1:0] dataOut,
    output logic                   dataOe,
    output logic                   waitOut,
    // Captured configuration
    output logic                   genericModeOn,
    output logic                   gpioAsInput,
    output logic                   bigEndian,
    output logic                   waitActiveHigh,
    output logic      [DIV_W-1:0]  clkDivSel,
    output logic      [DIV_W-1:0]  busClkDivTick
);
    // Elaboration checks: the logic below assumes these shapes.
    if (REV_ID == 8'h00) begin : gRevIdCheck
        $error("Revision id must be nonzero.");
    end
    if (MODE_LSB + MODE_W > STRAP_W) begin : gModeCheck
        $error("Mode field lies outside the straps.");
    end
    if (DIV_LSB + DIV_W > STRAP_W) begin : gDivCheck
        $error("Divider field lies outside the straps.");
    end
    if (GPIO_IN_BIT >= STRAP_W || ENDIAN_BIT >= STRAP_W
            || WAITPOL_BIT >= STRAP_W) begin : gBitCheck
        $error("A single strap bit lies outside the straps.");
    end
    if (DATA_W != 16) begin : gWidthCheck
        // Byte swapping and the two write enables assume a 16-bit port.
        $error("Host data must be 16 bits wide.");
    end
    if (BUF_WORDS > (1 << BUF_AW) || BUF_AW >= ADDR_W) begin : gBufCheck
        $error("Display buffer does not fit its address bits.");
    end
    if (REG_LAT < 0 || REG_LAT > 3) begin : gLatCheck
        // The latency counter is two bits wide.
        $error("Register latency does not fit its counter.");
    end

    // All state of the port except the registered outputs lives in one record.
    typedef struct packed {
        logic                armed;
        logic [STRAP_W-1:0]  strap;
        hpsc_state_t         state;
        logic                isMem;
        logic                isWrite;
        logic [1:0]          cnt;
        logic [DATA_W-1:0]   rdat;
        logic                oe;
        logic                waitOn;
        logic [DIV_W-1:0]    divCnt;
    } hpsc_st_t;

    hpsc_st_t st_ff;
    hpsc_st_t nxt_st;
    logic [DATA_W-1:0] memRdata;
    logic              memEn;
    logic              memWe;

    // Swap bytes for a big-endian host.
    function automatic logic [DATA_W-1:0] orderBytes(input logic [DATA_W-1:0] d,
                                                     input logic big);
        return big ? {d[7:0], d[15:8]} : d;
    endfunction

    // Map the host byte enables onto the stored word lanes.
    function automatic logic [1:0] laneEnables(input logic [1:0] enN, input logic big);
        return big ? {~enN[0], ~enN[1]} : ~enN;
    endfunction

    // Turn the busy state into the strapped wait level.
    function automatic logic waitLevel(input logic busy, input logic actHigh);
        return actHigh ? busy : !busy;
    endfunction

    logic              reqRd;
    logic              reqWr;
    logic              bigE;
    logic [1:0]        memBe;
    logic [BUF_AW-1:0] bufWordAddr;
    logic              hostRelease;
    logic [DATA_W-1:0] revWord;
    assign reqRd       = !csN && !rdN;
    assign reqWr       = !csN && (weN != 2'h3);
    assign bigE        = st_ff.strap[ENDIAN_BIT];
    assign memBe       = laneEnables(weN, bigE);
    assign bufWordAddr = addr[BUF_AW:1];
    // A read ends once the host lifts its select or both strobes.
    assign hostRelease = csN || (rdN && weN == 2'h3);
    assign revWord     = {8'h00, REV_ID};
    // The buffer is enabled only on the edge that takes a request.
    assign memEn       = (st_ff.state == HPSC_IDLE) && st_ff.armed
                         && (reqRd || reqWr) && memRegSel;
    assign memWe       = reqWr;

    hpsc_mem #(
        .WORDS (BUF_WORDS),
        .AW    (BUF_AW),
        .DW    (DATA_W)
    ) uMem (
        .clk   (clk),
        .en    (memEn),
        .we    (memWe),
        .be    (memBe),
        .addr  (bufWordAddr),
        .wdata (orderBytes(dataIn, bigE)),
        .rdata (memRdata)
    );

    always_comb begin
        nxt_st = st_ff;
        // Straps are taken only in the first cycle after release, then frozen.
        if (!st_ff.armed) begin
            nxt_st.armed = 1'b1;
            nxt_st.strap = configStrap;
        end
        nxt_st.divCnt = (st_ff.divCnt == st_ff.strap[DIV_LSB +: DIV_W]) ? '0
                        : DIV_W'(st_ff.divCnt + 2'h1);
        unique case (st_ff.state)
            HPSC_IDLE: begin
                if (st_ff.armed && (reqRd || reqWr)) begin
                    nxt_st.state   = HPSC_WAIT;
                    nxt_st.isMem   = memRegSel;
                    nxt_st.isWrite = reqWr;
                    nxt_st.cnt     = 2'(REG_LAT);
                    nxt_st.waitOn  = 1'b1;
                    if (!memRegSel && !reqWr) begin
                        nxt_st.rdat = (addr == REV_ID_OFFSET) ? revWord : '0;
                    end
                end
            end
            HPSC_WAIT: begin
                if (st_ff.cnt != 2'h0) begin
                    nxt_st.cnt = 2'(st_ff.cnt - 2'h1);
                end else begin
                    nxt_st.state  = HPSC_DONE;
                    nxt_st.waitOn = 1'b0;
                    if (!st_ff.isWrite) begin
                        nxt_st.oe = 1'b1;
                        if (st_ff.isMem) begin
                            nxt_st.rdat = orderBytes(memRdata, bigE);
                        end else begin
                            nxt_st.rdat = orderBytes(st_ff.rdat, bigE);
                        end
                    end
                end
            end
            HPSC_DONE: begin
                // Hold the answer until the host ends its strobe.
                if (hostRelease) begin
                    nxt_st.state = HPSC_IDLE;
                    nxt_st.oe    = 1'b0;
                end
            end
            default: begin
                nxt_st.state = HPSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff          <= '0;
            dataOut        <= '0;
            dataOe         <= 1'b0;
            waitOut        <= 1'b0;
            genericModeOn  <= 1'b0;
            gpioAsInput    <= 1'b0;
            bigEndian      <= 1'b0;
            waitActiveHigh <= 1'b0;
            clkDivSel      <= '0;
            busClkDivTick  <= '0;
        end else begin
            // Outputs follow the next state so they change together with it.
            st_ff          <= nxt_st;
            dataOut        <= nxt_st.rdat;
            dataOe         <= nxt_st.oe;
            waitOut        <= waitLevel(nxt_st.waitOn, nxt_st.strap[WAITPOL_BIT]);
            genericModeOn  <= nxt_st.strap[MODE_LSB +: MODE_W] == MODE_GENERIC1;
            gpioAsInput    <= nxt_st.strap[GPIO_IN_BIT];
            bigEndian      <= nxt_st.strap[ENDIAN_BIT];
            waitActiveHigh <= nxt_st.strap[WAITPOL_BIT];
            clkDivSel      <= nxt_st.strap[DIV_LSB +: DIV_W];
            busClkDivTick  <= nxt_st.divCnt;
        end
    end
endmodule

// ---- sim/hpsc_checker.sv ----
// Checker of strap capture and host port timing.
`timescale 1ns/1ns
module hpsc_checker import hpsc_pkg::*; #(
    parameter logic [7:0] REV_ID = REV_ID_VALUE
) (
    // Clock, reset and straps
    input wire logic               clk,
    input wire logic               nrst,
    input wire logic [STRAP_W-1:0] configStrap,
    // Host bus
    input wire logic               csN,
    input wire logic               memRegSel,
    input wire logic               rdN,
    input wire logic               dataOe,
    input wire logic               waitOut,
    input wire logic [ADDR_W-1:0]  addr,
    input wire logic [1:0]         weN,
    input wire logic [DATA_W-1:0]  dataOut,
    // Captured configuration
    input wire logic               genericModeOn,
    input wire logic               gpioAsInput,
    input wire logic               bigEndian,
    input wire logic               waitActiveHigh,
    input wire logic [DIV_W-1:0]   clkDivSel,
    input wire logic [DIV_W-1:0]   busClkDivTick
);
    logic [1:0] edgeCnt;
    logic [7:0] capStrap;
    // Own copy of the straps, so a capture at the wrong edge shows up.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            edgeCnt <= 2'h0;
            capStrap <= 8'h00;
        end else begin
            if (edgeCnt != 2'h3) edgeCnt <= edgeCnt + 2'h1;
            if (edgeCnt == 2'h0) capStrap <= configStrap;
        end
    end
    wire ready = edgeCnt == 2'h3;
    wire waitOn = waitOut == waitActiveHigh;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence reqStart; $fell(csN) && (!rdN || weN != 2'h3); endsequence
    sequence waitPulse; waitOn [*2] ##1 !waitOn; endsequence
    a_mode_decode: assert property (ready |-> genericModeOn == (capStrap[2:0] == 3'h3))
        else $error("mode flag wrong");
    a_gpio_dir: assert property (ready |-> gpioAsInput == capStrap[3])
        else $error("gpio direction wrong");
    a_byte_order: assert property (ready |-> bigEndian == capStrap[4])
        else $error("byte order wrong");
    a_wait_pol: assert property (ready |-> waitActiveHigh == capStrap[5])
        else $error("wait polarity wrong");
    a_clk_div: assert property (ready |-> clkDivSel == capStrap[7:6])
        else $error("divider select wrong");
    a_strap_hold: assert property (ready |-> $stable({genericModeOn, gpioAsInput, bigEndian,
        waitActiveHigh, clkDivSel}))
        else $error("captured straps moved");
    a_wait_pulse: assert property (reqStart |-> !waitOn ##1 waitPulse)
        else $error("wait pulse wrong");
    a_oe_after_wait: assert property ($rose(dataOe) |-> !waitOn)
        else $error("data driven during wait");
    a_oe_release: assert property ($rose(rdN) |=> !dataOe)
        else $error("data not released");
    a_rev_read: assert property (reqStart ##0 (!rdN && !memRegSel && addr == REV_ID_OFFSET)
        |-> ##4 dataOe && dataOut == (bigEndian ? {REV_ID, 8'h00} : {8'h00, REV_ID}))
        else $error("revision read wrong");
    a_div_wrap: assert property (busClkDivTick == clkDivSel |=> busClkDivTick == 2'h0)
        else $error("divider did not wrap");
    a_div_step: assert property (busClkDivTick != clkDivSel |=>
        busClkDivTick == 2'($past(busClkDivTick) + 2'h1))
        else $error("divider did not count");
endmodule
bind hpsc_top hpsc_checker #(.REV_ID(REV_ID)) chk_u (
    .clk            (clk),
    .nrst           (nrst),
    .configStrap    (configStrap),
    .csN            (csN),
    .memRegSel      (memRegSel),
    .rdN            (rdN),
    .dataOe         (dataOe),
    .waitOut        (waitOut),
    .addr           (addr),
    .weN            (weN),
    .dataOut        (dataOut),
    .genericModeOn  (genericModeOn),
    .gpioAsInput    (gpioAsInput),
    .bigEndian      (bigEndian),
    .waitActiveHigh (waitActiveHigh),
    .clkDivSel      (clkDivSel),
    .busClkDivTick  (busClkDivTick)
);

// ---- sim/hpsc_host_bfm.sv ----
// Host bus master that ends each access on the device wait line.
`timescale 1ns/1ns
module hpsc_host_bfm import hpsc_pkg::*; (
    // Device answer
    input  wire logic              clk,
    input  wire logic              waitOut,
    input  wire logic              waitActiveHigh,
    input  wire logic [DATA_W-1:0] dataOut,
    // Host bus
    output logic                   csN,
    output logic                   memRegSel,
    output logic                   rdN,
    output logic      [ADDR_W-1:0] addr,
    output logic      [1:0]        weN,
    output logic      [DATA_W-1:0] dataIn
);
    initial {csN, rdN, weN, memRegSel, addr, dataIn} = '1;
    // Single 16-bit transfers only; no burst is ever issued.
    task automatic xfer(input logic sel, input logic [ADDR_W-1:0] a, input logic wr,
                        input logic [1:0] beN, input logic [DATA_W-1:0] wd,
                        output logic [DATA_W-1:0] rd, output logic ok);
        int ph;
        ok = 1'b0;
        ph = 0;
        memRegSel = sel;
        addr = a;
        dataIn = wd;
        @(posedge clk);
        #1;
        csN = 1'b0;
        rdN = wr;
        weN = wr ? beN : 2'h3;
        for (int n = 0; n < 20 && !ok; n++) begin
            @(posedge clk);
            if (ph == 0 && waitOut == waitActiveHigh) ph = 1;
            else if (ph == 1 && waitOut != waitActiveHigh) ok = 1'b1;
        end
        rd = dataOut;
        #1;
        {csN, rdN, weN} = '1;
        addr = ~a;
        dataIn = ~wd;
        memRegSel = ~sel;
        @(posedge clk);
        #1;
    endtask
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench of the strap capture and host port.
`timescale 1ns/1ns
module tb_top;
    import hpsc_pkg::*;
    logic clk, nrst, csN, memRegSel, rdN, dataOe, waitOut, ok;
    logic genericModeOn, gpioAsInput, bigEndian, waitActiveHigh;
    logic [STRAP_W-1:0] configStrap;
    logic [ADDR_W-1:0] addr;
    logic [1:0] weN, clkDivSel;
    logic [DATA_W-1:0] dataIn, dataOut, rd;
    int bad_count = 0;
    int total_checks = 0;
    logic [7:0] straps [4] = '{8'h2B, 8'hF4, 8'h43, 8'h98};
    hpsc_top dut_u (
        .clk            (clk),
        .nrst           (nrst),
        .configStrap    (configStrap),
        .csN            (csN),
        .memRegSel      (memRegSel),
        .addr           (addr),
        .rdN            (rdN),
        .weN            (weN),
        .dataIn         (dataIn),
        .dataOut        (dataOut),
        .dataOe         (dataOe),
        .waitOut        (waitOut),
        .genericModeOn  (genericModeOn),
        .gpioAsInput    (gpioAsInput),
        .bigEndian      (bigEndian),
        .waitActiveHigh (waitActiveHigh),
        .clkDivSel      (clkDivSel),
        .busClkDivTick  ()
    );
    hpsc_host_bfm host_u (
        .clk            (clk),
        .waitOut        (waitOut),
        .waitActiveHigh (waitActiveHigh),
        .dataOut        (dataOut),
        .csN            (csN),
        .memRegSel      (memRegSel),
        .rdN            (rdN),
        .addr           (addr),
        .weN            (weN),
        .dataIn         (dataIn)
    );
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic go(input logic sel, input logic [16:0] a, input logic wr,
                      input logic [1:0] beN, input logic [15:0] wd);
        host_u.xfer(sel, a, wr, beN, wd, rd, ok);
        if (ok !== 1'b1) begin
            bad_count++;
            $display("ERROR %0t no acknowledge", $time);
            give_verdict();
        end
    endtask
    initial begin
        foreach (straps[i]) begin
            nrst = 1'b0;
            configStrap = straps[i];
            repeat (3) @(posedge clk);
            #1 nrst = 1'b1;
            repeat (4) @(posedge clk);
            // Moving the pins after capture must leave the setup alone.
            #1 configStrap = ~straps[i];
            repeat (2) @(posedge clk);
            #1;
            check(16'({genericModeOn, gpioAsInput, bigEndian, waitActiveHigh, clkDivSel}),
                  16'({straps[i][2:0] == MODE_GENERIC1, straps[i][GPIO_IN_BIT],
                       straps[i][ENDIAN_BIT], straps[i][WAITPOL_BIT],
                       straps[i][DIV_LSB +: DIV_W]}));
            go(1'b0, REV_ID_OFFSET, 1'b0, 2'h3, 16'h0000);
            check(rd, straps[i][4] ? {REV_ID_VALUE, 8'h00} : {8'h00, REV_ID_VALUE});
            go(1'b1, 17'h00002, 1'b1, 2'h0, 16'hA5C3 ^ 16'(i));
            go(1'b1, 17'h00002, 1'b0, 2'h3, 16'h0000);
            check(rd, 16'hA5C3 ^ 16'(i));
            go(1'b1, 17'h00002, 1'b1, 2'h2, 16'h0011);
            go(1'b1, 17'h00002, 1'b0, 2'h3, 16'h0000);
            check(rd, {8'hA5, 8'h11});
            go(1'b0, 17'h00002, 1'b0, 2'h3, 16'h0000);
            check(rd, 16'h0000);
            $display("strap test %0d done", i);
        end
        give_verdict();
    end
endmodule
